// ### cpu_status_low_byte.sv
// Processor status word low byte with saturation stickies and event interrupt
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module cpu_status_low_byte
   import cpu_status_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_nrst,
   // Register port
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wr_data,
   input  wire logic              i_wr_en,
   input  wire logic              i_rd_en,
   output logic      [DATA_W-1:0] o_rd_data,
   // Core control and interrupt control inputs
   input  wire logic              i_priority_level_msb,
   input  wire logic              i_nesting_disable,
   // Interrupt controller priority load
   input  wire logic              i_ipl_load,
   input  wire logic [2:0]        i_ipl_value,
   // Repeat loop sequencer
   input  wire logic              i_repeat_loop_active,
   // ALU result flags
   input  wire logic              i_alu_valid,
   input  wire logic [ARITH_W-1:0] i_alu_affect,
   input  wire logic              i_alu_neg,
   input  wire logic              i_alu_ovf,
   input  wire logic              i_alu_zero,
   input  wire logic              i_alu_carry,
   // Accumulator saturation events
   input  wire logic              i_sat_a,
   input  wire logic              i_sat_b,
   // Outputs
   output logic      [3:0]        o_cpu_priority,
   output logic                   o_user_irq_block,
   output logic      [DATA_W-1:0] o_status_word,
   output logic                   o_irq
);

   // ==========================================================================
   // Helpers
   function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                input logic [ADDR_W-1:0] off);
      hit = (addr == off);
   endfunction : hit

   // Next value of one arithmetic flag; an affecting ALU result beats a store
   function automatic logic flag_next(input logic cur,
                                      input logic alu_en,
                                      input logic alu_val,
                                      input logic sw_en,
                                      input logic sw_val);
      flag_next = cur;
      if (alu_en) begin
         flag_next = alu_val;
      end else if (sw_en) begin
         flag_next = sw_val;
      end
   endfunction : flag_next

   // A stored zero in its own bit or in the combined bit clears a sticky
   function automatic logic sat_clear(input logic              wr,
                                      input logic [DATA_W-1:0] data,
                                      input int unsigned       own_bit);
      sat_clear = wr && (!data[own_bit] || !data[BIT_COMB_SAT]);
   endfunction : sat_clear

   // Event vectors read back zero-extended to the bus width
   function automatic logic [DATA_W-1:0] evt_word(input logic [EVT_W-1:0] v);
      evt_word             = '0;
      evt_word[EVT_W-1:0]  = v;
   endfunction : evt_word

   // ==========================================================================
   // Declarations
   logic [2:0]         prio_q;
   logic [2:0]         prio_d;
   logic [ARITH_W-1:0] arith_q;
   logic [ARITH_W-1:0] arith_d;
   logic [ARITH_W-1:0] alu_vec;
   logic               repeat_q;
   logic [EVT_W-1:0]   mask_q;
   logic [DATA_W-1:0]  rd_data_q;
   logic [DATA_W-1:0]  rd_data_d;

   logic               wr_status;
   logic               wr_evt_status;
   logic               wr_evt_mask;

   logic [1:0]         sat_set;
   logic [1:0]         sat_clr;
   logic [1:0]         sat_flags;
   logic               comb_sat;

   logic [EVT_W-1:0]   evt_set;
   logic [EVT_W-1:0]   evt_clr;
   logic [EVT_W-1:0]   evt_flags;
   logic               ovf_event;

   logic [ARITH_W-1:0] alu_take;
   logic               prio_sw_wr;
   logic               rd_status;
   logic               rd_evt_status;
   logic               rd_evt_mask;
   logic [EVT_W-1:0]   evt_pending;

   // ==========================================================================
   // Address decode
   assign wr_status     = i_wr_en && hit(i_addr, OFF_STATUS_WORD);
   assign wr_evt_status = i_wr_en && hit(i_addr, OFF_EVT_STATUS);
   assign wr_evt_mask   = i_wr_en && hit(i_addr, OFF_EVT_MASK);
   assign rd_status     = i_rd_en && hit(i_addr, OFF_STATUS_WORD);
   assign rd_evt_status = i_rd_en && hit(i_addr, OFF_EVT_STATUS);
   assign rd_evt_mask   = i_rd_en && hit(i_addr, OFF_EVT_MASK);

   // ==========================================================================
   // Priority field
   // Software store honoured only while nesting is enabled
   assign prio_sw_wr = wr_status && !i_nesting_disable;

   // Interrupt controller entry and return take precedence over software,
   // since a vectored load must never be undone by a racing store
   always_comb begin
      prio_d = prio_q;
      if (i_ipl_load) begin
         prio_d = i_ipl_value;
      end else if (prio_sw_wr) begin
         prio_d = i_wr_data[PRIO_HI:PRIO_LO];
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         prio_q <= PRIO_RST;
      end else begin
         prio_q <= prio_d;
      end
   end

   // Effective level: MSB from core control sits above the field
   // MSB is taken live, so a change in core control shows at once
   assign o_cpu_priority = {i_priority_level_msb, prio_q};

   assign o_user_irq_block = i_priority_level_msb
                           || (prio_q == PRIO_BLOCK_CODE);

   // ==========================================================================
   // Repeat loop indication
   // One cycle late, in step with the flags of the same instruction
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         repeat_q <= 1'h0;
      end else begin
         repeat_q <= i_repeat_loop_active;
      end
   end

   // ==========================================================================
   // Arithmetic flags
   // Vector order matches the status bit positions of carry to negative
   always_comb begin
      alu_vec            = ARITH_RST;
      alu_vec[BIT_NEG]   = i_alu_neg;
      alu_vec[BIT_OVF]   = i_alu_ovf;
      alu_vec[BIT_ZERO]  = i_alu_zero;
      alu_vec[BIT_CARRY] = i_alu_carry;
   end

   // Only a completing op may touch the flags; idle affect lines are junk
   assign alu_take = i_alu_valid ? i_alu_affect : '0;

   // ALU result beats a software store to the same flag in the same cycle
   always_comb begin
      arith_d = arith_q;
      for (int i = 0; i < ARITH_W; i++) begin
         arith_d[i] = flag_next(arith_q[i], alu_take[i], alu_vec[i],
                                wr_status, i_wr_data[i]);
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         arith_q <= ARITH_RST;
      end else begin
         arith_q <= arith_d;
      end
   end

   // ==========================================================================
   // Saturation stickies
   // Writing zero clears; writing one has no effect, so a read-modify-write
   // of the status word leaves the stickies as they were
   assign sat_set[0] = i_sat_a;
   assign sat_set[1] = i_sat_b;

   assign sat_clr[0] = sat_clear(wr_status, i_wr_data, BIT_ACC_A_SAT);
   assign sat_clr[1] = sat_clear(wr_status, i_wr_data, BIT_ACC_B_SAT);

   sticky_flags #(
      .W       (2)
   ) u_sat_sticky (
      .i_clk   (i_clk),
      .i_nrst  (i_nrst),
      .i_set   (sat_set),
      .i_clr   (sat_clr),
      .o_flags (sat_flags)
   );

   // Combined sticky has no storage of its own
   assign comb_sat = |sat_flags;

   // ==========================================================================
   // Status word image
   // Unmapped bits read zero; combined bit is the OR of both stickies
   always_comb begin
      o_status_word                  = '0;
      o_status_word[BIT_ACC_A_SAT]   = sat_flags[0];
      o_status_word[BIT_ACC_B_SAT]   = sat_flags[1];
      o_status_word[BIT_COMB_SAT]    = comb_sat;
      o_status_word[PRIO_HI:PRIO_LO] = prio_q;
      o_status_word[BIT_REPEAT]      = repeat_q;
      o_status_word[ARITH_W-1:0]     = arith_q;
   end

   // ==========================================================================
   // Event interrupt
   // Overflow event fires only when an affecting ALU op reports overflow
   assign ovf_event = alu_take[BIT_OVF] && i_alu_ovf;

   always_comb begin
      evt_set            = '0;
      evt_set[EVT_SAT_A] = i_sat_a;
      evt_set[EVT_SAT_B] = i_sat_b;
      evt_set[EVT_OVF]   = ovf_event;
   end

   // Set wins over a write-one clear landing in the same cycle
   assign evt_clr = wr_evt_status ? i_wr_data[EVT_W-1:0] : '0;

   sticky_flags #(
      .W       (EVT_W)
   ) u_evt_sticky (
      .i_clk   (i_clk),
      .i_nrst  (i_nrst),
      .i_set   (evt_set),
      .i_clr   (evt_clr),
      .o_flags (evt_flags)
   );

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         mask_q <= EVT_MASK_RST;
      end else if (wr_evt_mask) begin
         mask_q <= i_wr_data[EVT_W-1:0];
      end
   end

   // Level output: high until every unmasked event is cleared
   assign evt_pending = evt_flags & mask_q;
   assign o_irq       = |evt_pending;

   // ==========================================================================
   // Read port
   // Data stand in the cycle after the strobe only; unmapped reads give zero
   always_comb begin
      rd_data_d = RD_DATA_RST;
      if (rd_status) begin
         rd_data_d = o_status_word;
      end else if (rd_evt_status) begin
         rd_data_d = evt_word(evt_flags);
      end else if (rd_evt_mask) begin
         rd_data_d = evt_word(mask_q);
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rd_data_q <= RD_DATA_RST;
      end else begin
         rd_data_q <= rd_data_d;
      end
   end

   assign o_rd_data = rd_data_q;

endmodule : cpu_status_low_byte

// ### cpu_status_pkg.sv
// Constants shared by the processor status word low byte and its helpers
package cpu_status_pkg;

   // ==========================================================================
   // Bus geometry
   localparam int unsigned DATA_W = 16;
   localparam int unsigned ADDR_W = 4;

   // ==========================================================================
   // Register offsets (word index on the plain register port)
   localparam logic [ADDR_W-1:0] OFF_STATUS_WORD = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_EVT_STATUS  = 4'h1;
   localparam logic [ADDR_W-1:0] OFF_EVT_MASK    = 4'h2;

   // ==========================================================================
   // Status word field positions
   localparam int unsigned BIT_ACC_A_SAT = 13;
   localparam int unsigned BIT_ACC_B_SAT = 12;
   localparam int unsigned BIT_COMB_SAT  = 10;
   localparam int unsigned PRIO_HI       = 7;
   localparam int unsigned PRIO_LO       = 5;
   localparam int unsigned BIT_REPEAT    = 4;
   localparam int unsigned BIT_NEG       = 3;
   localparam int unsigned BIT_OVF       = 2;
   localparam int unsigned BIT_ZERO      = 1;
   localparam int unsigned BIT_CARRY     = 0;

   // Arithmetic flag vector index, same order as the low status bits
   localparam int unsigned ARITH_W       = 4;

   // ==========================================================================
   // Event status and mask layout
   localparam int unsigned EVT_W         = 3;
   localparam int unsigned EVT_SAT_A     = 0;
   localparam int unsigned EVT_SAT_B     = 1;
   localparam int unsigned EVT_OVF       = 2;

   // ==========================================================================
   // Reset values and fixed codes
   localparam logic [2:0]         PRIO_RST         = 3'h0;
   localparam logic [2:0]         PRIO_BLOCK_CODE  = 3'h7;
   localparam logic [ARITH_W-1:0] ARITH_RST        = 4'h0;
   localparam logic [EVT_W-1:0]   EVT_MASK_RST     = 3'h0;
   localparam logic [DATA_W-1:0]  RD_DATA_RST      = 16'h0000;

endpackage : cpu_status_pkg

// ### sticky_flags.sv
// Bank of sticky flags: hardware sets, software or logic clears, set wins
`timescale 1ns/100ps
module sticky_flags #(
   parameter int unsigned W = 2
) (
   input  wire logic         i_clk,
   input  wire logic         i_nrst,
   input  wire logic [W-1:0] i_set,
   input  wire logic [W-1:0] i_clr,
   output logic      [W-1:0] o_flags
);

   logic [W-1:0] flags_q;

   // ==========================================================================
   // Storage
   // A set in the same cycle as a clear must survive, so set is ORed last
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         flags_q <= '0;
      end else begin
         flags_q <= (flags_q & ~i_clr) | i_set;
      end
   end

   assign o_flags = flags_q;

endmodule : sticky_flags

// ### cpu_status_low_byte_props.sv
// Concurrent checks on the status word low byte ports
`timescale 1ns/100ps
module cpu_status_low_byte_chk
   import cpu_status_pkg::*;
(
   input wire logic               i_clk,
   input wire logic               i_nrst,
   input wire logic [ADDR_W-1:0]  i_addr,
   input wire logic               i_wr_en,
   input wire logic               i_priority_level_msb,
   input wire logic               i_nesting_disable,
   input wire logic               i_ipl_load,
   input wire logic               i_repeat_loop_active,
   input wire logic               i_alu_valid,
   input wire logic [ARITH_W-1:0] i_alu_affect,
   input wire logic               i_alu_neg,
   input wire logic               i_alu_carry,
   input wire logic               i_sat_a,
   input wire logic [3:0]         o_cpu_priority,
   input wire logic               o_user_irq_block,
   input wire logic [DATA_W-1:0]  o_status_word
);
   // ==========================================================================
   // Properties
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   a_prio_concat: assert property (
      o_cpu_priority == {i_priority_level_msb, o_status_word[PRIO_HI:PRIO_LO]})
      else $error("priority level not msb over field");
   a_msb_blocks: assert property (
      i_priority_level_msb |-> o_user_irq_block)
      else $error("msb set but user interrupts open");
   a_code_blocks: assert property (
      !i_priority_level_msb |->
      o_user_irq_block == (o_status_word[PRIO_HI:PRIO_LO] == PRIO_BLOCK_CODE))
      else $error("block output wrong for field code");
   a_prio_locked: assert property (
      i_wr_en && i_addr == OFF_STATUS_WORD && i_nesting_disable && !i_ipl_load
      |=> $stable(o_status_word[PRIO_HI:PRIO_LO]))
      else $error("priority field written while locked");
   a_repeat_follow: assert property (
      $past(i_nrst) |-> o_status_word[BIT_REPEAT] == $past(i_repeat_loop_active))
      else $error("repeat bit does not follow sequencer");
   a_neg_update: assert property (
      i_alu_valid && i_alu_affect[3] |=> o_status_word[BIT_NEG] == $past(i_alu_neg))
      else $error("negative flag not taken");
   a_carry_update: assert property (
      i_alu_valid && i_alu_affect[0] |=> o_status_word[BIT_CARRY] == $past(i_alu_carry))
      else $error("carry flag not taken");
   a_zero_hold: assert property (
      i_alu_valid && !i_alu_affect[1] && !(i_wr_en && i_addr == OFF_STATUS_WORD)
      |=> $stable(o_status_word[BIT_ZERO]))
      else $error("unaffected zero flag changed");
   a_sat_sticky: assert property (
      i_sat_a |=> o_status_word[BIT_ACC_A_SAT] && o_status_word[BIT_COMB_SAT])
      else $error("saturation sticky not set");
   c_full_block: cover property (i_priority_level_msb && o_status_word[7:5] == 3'h7);
   c_all_flags: cover property (i_alu_valid && i_alu_affect == 4'hF);
   c_sat_a: cover property (i_sat_a);
endmodule : cpu_status_low_byte_chk

bind cpu_status_low_byte cpu_status_low_byte_chk chk (.i_clk, .i_nrst, .i_addr, .i_wr_en,
   .i_priority_level_msb, .i_nesting_disable, .i_ipl_load, .i_repeat_loop_active,
   .i_alu_valid, .i_alu_affect, .i_alu_neg, .i_alu_carry, .i_sat_a, .o_cpu_priority,
   .o_user_irq_block, .o_status_word);

// ### cpu_side_model.sv
// Behavioural ALU, loop sequencer and saturation source facing the block
`timescale 1ns/100ps
module cpu_side_model (
   input  wire logic       i_clk,
   input  wire logic       i_op,
   input  wire logic [3:0] i_aff,
   input  wire logic [3:0] i_res,
   input  wire logic [1:0] i_sat,
   input  wire logic       i_rpt,
   output logic            o_valid,
   output logic [3:0]      o_affect,
   output logic [3:0]      o_res,
   output logic [1:0]      o_sat,
   output logic            o_rpt
);
   // ==========================================================================
   // One registered beat per request
   always_ff @(posedge i_clk) begin
      o_valid  <= i_op;
      o_affect <= i_aff;
      // Idle result lines carry junk so held flags are really tested
      o_res    <= i_op ? i_res : ~i_res;
      o_sat    <= i_sat;
      o_rpt    <= i_rpt;
   end
endmodule : cpu_side_model

// ### tb_cpu_status_low_byte.sv
// Self-checking bench for the status word low byte
`timescale 1ns/100ps
module tb_cpu_status_low_byte
   import cpu_status_pkg::*;
;
   logic        clk = 1'h0, nrst = 1'h0, we = 1'h0, re = 1'h0, msb = 1'h0;
   logic        nest = 1'h0, ipl_ld = 1'h0, op = 1'h0, rpt = 1'h0;
   logic [3:0]  addr = 4'h0, aff = 4'h0, res = 4'h0;
   logic [15:0] wdat = 16'h0000;
   logic [2:0]  ipl_v = 3'h0;
   logic [1:0]  sat = 2'h0, sat_m;
   logic        v_m, rpt_m, blk, irq;
   logic [3:0]  aff_m, res_m, prio;
   logic [15:0] rdat, sw;
   int          error_cnt = 0, checks_done = 0, cyc = 0;
   always #2 clk = ~clk;
   cpu_side_model model (.i_clk(clk), .i_op(op), .i_aff(aff), .i_res(res), .i_sat(sat),
      .i_rpt(rpt), .o_valid(v_m), .o_affect(aff_m), .o_res(res_m), .o_sat(sat_m),
      .o_rpt(rpt_m));
   cpu_status_low_byte uut (.i_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wr_data(wdat),
      .i_wr_en(we), .i_rd_en(re), .o_rd_data(rdat), .i_priority_level_msb(msb),
      .i_nesting_disable(nest), .i_ipl_load(ipl_ld), .i_ipl_value(ipl_v),
      .i_repeat_loop_active(rpt_m), .i_alu_valid(v_m), .i_alu_affect(aff_m),
      .i_alu_neg(res_m[3]), .i_alu_ovf(res_m[2]), .i_alu_zero(res_m[1]),
      .i_alu_carry(res_m[0]), .i_sat_a(sat_m[0]), .i_sat_b(sat_m[1]),
      .o_cpu_priority(prio), .o_user_irq_block(blk), .o_status_word(sw), .o_irq(irq));
   // ==========================================================================
   // Shared tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      addr <= a;
      wdat <= d;
      we <= 1'h1;
      @(posedge clk);
      we <= 1'h0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      addr <= a;
      re <= 1'h1;
      @(posedge clk);
      re <= 1'h0;
      #1;
      check(rdat, exp);
      @(posedge clk);
   endtask : rd
   task automatic pulse(input logic [1:0] v);
      sat <= v;
      @(posedge clk);
      sat <= 2'h0;
      @(posedge clk);
      #1;
   endtask : pulse
   task automatic complete_run();
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   // ==========================================================================
   // Scenarios
   task automatic t_reset();
      rd(OFF_STATUS_WORD, 16'h0000);
      rd(OFF_EVT_MASK, 16'h0000);
      rd(4'hF, 16'h0000);
   endtask : t_reset
   task automatic t_prio();
      for (int m = 0; m < 2; m++) begin
         for (int c = 0; c < 8; c++) begin
            msb <= m[0];
            wr(OFF_STATUS_WORD, {8'h00, c[2:0], 5'h00});
            #1;
            check(16'(prio), {12'h000, m[0], c[2:0]});
            check(16'(blk), 16'(m == 1 || c == 7));
            @(posedge clk);
            rd(OFF_STATUS_WORD, {8'h00, c[2:0], 5'h00});
         end
      end
   endtask : t_prio
   task automatic t_nest();
      msb <= 1'h0;
      wr(OFF_STATUS_WORD, 16'h0060);
      nest <= 1'h1;
      wr(OFF_STATUS_WORD, 16'h00E0);
      #1;
      check(sw, 16'h0060);
      @(posedge clk);
      ipl_ld <= 1'h1;
      ipl_v <= 3'h5;
      @(posedge clk);
      ipl_ld <= 1'h0;
      nest <= 1'h0;
      @(posedge clk);
      #1;
      check(16'(prio), 16'h0005);
      @(posedge clk);
   endtask : t_nest
   task automatic t_flags();
      // Each entry: affect, result, expected low nibble
      logic [11:0] tbl [4] = '{12'hFBB, 12'h44F, 12'h30C, 12'hC00};
      foreach (tbl[i]) begin
         op <= 1'h1;
         aff <= tbl[i][11:8];
         res <= tbl[i][7:4];
         @(posedge clk);
         op <= 1'h0;
         @(posedge clk);
         #1;
         check(16'(sw[3:0]), 16'(tbl[i][3:0]));
         @(posedge clk);
      end
   endtask : t_flags
   task automatic t_sat();
      pulse(2'h1);
      check(sw & 16'h3400, 16'h2400);
      @(posedge clk);
      wr(OFF_EVT_MASK, 16'h0007);
      rd(OFF_EVT_STATUS, 16'h0005);
      check(16'(irq), 16'h0001);
      wr(OFF_STATUS_WORD, 16'h34A0);
      rd(OFF_STATUS_WORD, 16'h24A0);
      wr(OFF_STATUS_WORD, 16'h20A0);
      rd(OFF_STATUS_WORD, 16'h00A0);
      wr(OFF_EVT_STATUS, 16'h0007);
      wr(OFF_EVT_MASK, 16'h0002);
      #1;
      check(16'(irq), 16'h0000);
      @(posedge clk);
      pulse(2'h2);
      check(16'(irq), 16'h0001);
      @(posedge clk);
      wr(OFF_EVT_MASK, 16'h0000);
      #1;
      check(16'(irq), 16'h0000);
      @(posedge clk);
   endtask : t_sat
   task automatic t_repeat();
      rpt <= 1'h1;
      @(posedge clk);
      @(posedge clk);
      #1;
      check(16'(sw[4]), 16'h0001);
      @(posedge clk);
      rpt <= 1'h0;
      @(posedge clk);
      @(posedge clk);
      #1;
      check(16'(sw[4]), 16'h0000);
   endtask : t_repeat
   // Run is under 150 cycles; ceiling leaves wide margin
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         complete_run();
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_reset();
      t_prio();
      t_nest();
      t_flags();
      t_sat();
      t_repeat();
      complete_run();
   end
endmodule : tb_cpu_status_low_byte
